// [src/spirk_pkg.sv]
// Purpose: shared types of the serial register port
// Assumes: constants live in spirk_regs.svh
// Notes:   types only
package spirk_pkg;
  typedef enum logic [1:0] {
    SPIRK_IDLE,
    SPIRK_CMD,
    SPIRK_READ,
    SPIRK_WRITE
  } spirk_state_e;
  typedef logic [15:0] spirk_word_t;
endpackage

// [src/spirk_regs.svh]
// Purpose: register map, field positions, reset values and codes
// Assumes: 15-bit register addresses, 16-bit registers
// Notes:   constants only
`ifndef SPIRK_REGS_SVH
`define SPIRK_REGS_SVH
`define SPIRK_ADDR_RESET_ID   15'h0000
`define SPIRK_ADDR_REVISION   15'h0001
`define SPIRK_ADDR_MAIN_ID    15'h4000
`define SPIRK_ADDR_KEY        15'h4008
`define SPIRK_ADDR_SCRATCH    15'h4009
`define SPIRK_UNLOCK_CODE     16'h9716
`define SPIRK_LOCK_CODE       16'h0000
`define SPIRK_KEY_RESET       16'h0000
`define SPIRK_SCRATCH_RESET   16'h0000
`define SPIRK_WORD_BITS       6'h20
`define SPIRK_ADDR_END        6'h10
`define SPIRK_DIR_BIT         31
`define SPIRK_ADDR_MSB        30
`define SPIRK_ADDR_LSB        16
`define SPIRK_SOFT_RESET_MAX  3'h6
`endif

// [src/spirk_top.sv]
// Purpose: four-wire serial register port with key lock and soft reset
// Assumes: REF_CLK well above serial clock; pins synchronised here
// Notes:   soft reset limit is cleared only by an on event or RST
`timescale 1ns/10ps
`include "spirk_regs.svh"
module spirk_top #(
  parameter logic [15:0] DEVICE_IDENTIFIER = 16'h5a5a, // arbitrary value
  parameter logic [15:0] MAIN_DIE_IDENTITY = 16'h1234, // arbitrary value
  parameter logic [7:0]  MAIN_DIE_REVISION = 8'h00,
  parameter logic [7:0]  SECONDARY_DIE_REVISION = 8'h00
) (
  // clock and reset
  input  wire logic REF_CLK,
  input  wire logic RST,
  // serial pins
  input  wire logic INTERFACE_SELECT_PIN,
  input  wire logic CHIP_SELECT_N,
  input  wire logic SERIAL_CLOCK_IN,
  input  wire logic SERIAL_DATA_IN,
  output logic      SERIAL_DATA_OUT_O,
  output logic      SERIAL_DATA_OUT_OE,
  // power state side
  input  wire logic SOFT_RESET_SCOPE_CONFIG,
  input  wire logic ON_EVENT,
  output logic      SOFT_RESET_PULSE,
  output logic      HOLD_OFF,
  output logic      PROTECT_UNLOCKED,
  // protected register write port
  output logic        PROT_WR_STROBE,
  output logic [14:0] PROT_WR_ADDR,
  output logic [15:0] PROT_WR_DATA,
  input  wire logic   PROT_ADDR_HIT,
  input  wire logic [15:0] EXT_RD_DATA
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage read only by the second
  logic [1:0] sel_s1_q, sel_s2_q;
  logic [1:0] cs_s1_q, cs_s2_q;
  logic [1:0] sck_s1_q, sck_s2_q;
  logic [1:0] sdi_s1_q, sdi_s2_q;
  logic [1:0] on_s1_q, on_s2_q;
  logic       cs_hist_q, sck_hist_q, on_hist_q;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      // stages start at each pin's idle level: no false edge after reset
      sel_s1_q <= 2'h0;
      cs_s1_q  <= 2'h3;
      sck_s1_q <= 2'h0;
      sdi_s1_q <= 2'h0;
      on_s1_q  <= 2'h0;
    end else begin
      sel_s1_q <= {sel_s1_q[0], INTERFACE_SELECT_PIN};
      cs_s1_q  <= {cs_s1_q[0], CHIP_SELECT_N};
      sck_s1_q <= {sck_s1_q[0], SERIAL_CLOCK_IN};
      sdi_s1_q <= {sdi_s1_q[0], SERIAL_DATA_IN};
      on_s1_q  <= {on_s1_q[0], ON_EVENT};
    end
  end
  // second stage is bit [1]; bit [0] is the first flip-flop
  assign sel_s2_q = sel_s1_q;
  assign cs_s2_q  = cs_s1_q;
  assign sck_s2_q = sck_s1_q;
  assign sdi_s2_q = sdi_s1_q;
  assign on_s2_q  = on_s1_q;

  logic sel_sync, cs_n_sync, sck_sync, sdi_sync, on_sync;
  assign sel_sync  = sel_s2_q[1];
  assign cs_n_sync = cs_s2_q[1];
  assign sck_sync  = sck_s2_q[1];
  assign sdi_sync  = sdi_s2_q[1];
  assign on_sync   = on_s2_q[1];

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cs_hist_q  <= 1'b1;
      sck_hist_q <= 1'b0;
      on_hist_q  <= 1'b0;
    end else begin
      cs_hist_q  <= cs_n_sync;
      sck_hist_q <= sck_sync;
      on_hist_q  <= on_sync;
    end
  end

  logic sck_rise, sck_fall, cs_rise, cs_fall, on_rise, spi_mode;
  assign spi_mode = sel_sync;
  assign sck_rise = spi_mode & ~cs_n_sync & sck_sync & ~sck_hist_q;
  assign sck_fall = spi_mode & ~cs_n_sync & ~sck_sync & sck_hist_q;
  assign cs_rise  = spi_mode & cs_n_sync & ~cs_hist_q;
  assign cs_fall  = ~cs_n_sync & cs_hist_q;
  assign on_rise  = on_sync & ~on_hist_q;

  ////////////////////////////////////////////////////////////////////////
  // frame receive
  spirk_pkg::spirk_state_e state_q;
  logic [31:0] shift_q;
  logic [5:0]  bit_cnt_q;
  logic [15:0] rd_shift_q;
  logic [4:0]  rd_left_q;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q   <= spirk_pkg::SPIRK_IDLE;
      shift_q   <= 32'h0;
      bit_cnt_q <= 6'h0;
    end else begin
      unique case (state_q)
        spirk_pkg::SPIRK_IDLE: begin
          if (cs_fall && spi_mode) begin
            state_q   <= spirk_pkg::SPIRK_CMD;
            bit_cnt_q <= 6'h0;
          end
        end
        spirk_pkg::SPIRK_CMD: begin
          if (cs_rise || !spi_mode) begin
            state_q <= spirk_pkg::SPIRK_IDLE;
          end else if (sck_rise) begin
            shift_q   <= {shift_q[30:0], sdi_sync};
            bit_cnt_q <= bit_cnt_q + 6'h1;
            if (bit_cnt_q == 6'h0f && shift_q[14]) begin
              state_q <= spirk_pkg::SPIRK_READ;
            end else if (bit_cnt_q == 6'h0f) begin
              state_q <= spirk_pkg::SPIRK_WRITE;
            end
          end
        end
        spirk_pkg::SPIRK_WRITE: begin
          if (!spi_mode) begin
            state_q <= spirk_pkg::SPIRK_IDLE;
          end else if (cs_rise) begin
            state_q <= spirk_pkg::SPIRK_IDLE;
          end else if (sck_rise) begin
            shift_q   <= {shift_q[30:0], sdi_sync};
            bit_cnt_q <= bit_cnt_q + 6'h1;
          end
        end
        spirk_pkg::SPIRK_READ: begin
          // data in no longer sampled once the address is held
          if (cs_rise || !spi_mode) begin
            state_q <= spirk_pkg::SPIRK_IDLE;
          end
        end
      endcase
    end
  end

  logic [14:0] cur_addr;
  assign cur_addr = shift_q[14:0];

  // a completed write: at least 32 bits seen before chip select rose
  logic wr_commit;
  assign wr_commit = cs_rise && (state_q == spirk_pkg::SPIRK_WRITE)
                     && !shift_q[`SPIRK_DIR_BIT]
                     && (bit_cnt_q >= `SPIRK_WORD_BITS);
  logic [14:0] wr_addr;
  logic [15:0] wr_data;
  assign wr_addr = shift_q[`SPIRK_ADDR_MSB:`SPIRK_ADDR_LSB];
  assign wr_data = shift_q[15:0];

  ////////////////////////////////////////////////////////////////////////
  // key, scratch, soft reset
  logic [15:0] key_q, scratch_q;
  logic [2:0]  sreset_cnt_q;
  logic        unlocked;
  logic        soft_rst_now;
  assign unlocked = (key_q == `SPIRK_UNLOCK_CODE);
  assign soft_rst_now = wr_commit && (wr_addr == `SPIRK_ADDR_RESET_ID);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      key_q <= `SPIRK_KEY_RESET;
    end else if (wr_commit && wr_addr == `SPIRK_ADDR_KEY) begin
      key_q <= wr_data;
    end else if (soft_rst_now && SOFT_RESET_SCOPE_CONFIG) begin
      key_q <= `SPIRK_KEY_RESET;
    end
  end

  // scratch has no power-state clear: RST clears it, as does a soft reset while SOFT_RESET_SCOPE_CONFIG is set
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      scratch_q <= `SPIRK_SCRATCH_RESET;
    end else if (wr_commit && wr_addr == `SPIRK_ADDR_SCRATCH) begin
      scratch_q <= wr_data;
    end else if (soft_rst_now && SOFT_RESET_SCOPE_CONFIG) begin
      scratch_q <= `SPIRK_SCRATCH_RESET;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sreset_cnt_q     <= 3'h0;
      SOFT_RESET_PULSE <= 1'b0;
      HOLD_OFF         <= 1'b0;
    end else begin
      SOFT_RESET_PULSE <= 1'b0;
      if (on_rise) begin
        // a reset request in the same cycle opens the new count
        sreset_cnt_q     <= {2'h0, soft_rst_now};
        SOFT_RESET_PULSE <= soft_rst_now;
        HOLD_OFF         <= 1'b0;
      end else if (soft_rst_now) begin
        if (sreset_cnt_q == `SPIRK_SOFT_RESET_MAX) begin
          HOLD_OFF <= 1'b1;
        end else begin
          sreset_cnt_q     <= sreset_cnt_q + 3'h1;
          SOFT_RESET_PULSE <= 1'b1;
        end
      end
    end
  end

  // outside protected writes pass only while unlocked
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PROT_WR_STROBE   <= 1'b0;
      PROT_WR_ADDR     <= 15'h0;
      PROT_WR_DATA     <= 16'h0;
      PROTECT_UNLOCKED <= 1'b0;
    end else begin
      PROTECT_UNLOCKED <= unlocked;
      PROT_WR_STROBE   <= wr_commit && PROT_ADDR_HIT && unlocked;
      if (wr_commit) begin
        PROT_WR_ADDR <= wr_addr;
        PROT_WR_DATA <= wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and open-drain output
  spirk_pkg::spirk_word_t rd_word;
  always_comb begin
    unique case (cur_addr)
      `SPIRK_ADDR_RESET_ID: rd_word = DEVICE_IDENTIFIER;
      `SPIRK_ADDR_REVISION: rd_word = {MAIN_DIE_REVISION,
                                       SECONDARY_DIE_REVISION};
      `SPIRK_ADDR_MAIN_ID:  rd_word = MAIN_DIE_IDENTITY;
      `SPIRK_ADDR_KEY:      rd_word = key_q;
      `SPIRK_ADDR_SCRATCH:  rd_word = scratch_q;
      default:              rd_word = EXT_RD_DATA;
    endcase
  end

  logic enter_read, rd_start_q, rd_msb;
  assign enter_read = (state_q == spirk_pkg::SPIRK_CMD) && sck_rise
                      && (bit_cnt_q == 6'h0f) && shift_q[14];
  assign rd_msb     = rd_shift_q[15];

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rd_shift_q         <= 16'h0;
      rd_left_q          <= 5'h0;
      rd_start_q         <= 1'b0;
      SERIAL_DATA_OUT_O  <= 1'b0;
      SERIAL_DATA_OUT_OE <= 1'b0;
    end else begin
      rd_start_q        <= enter_read;
      SERIAL_DATA_OUT_O <= 1'b0;
      if (state_q != spirk_pkg::SPIRK_READ || cs_rise) begin
        SERIAL_DATA_OUT_OE <= 1'b0;
        rd_left_q          <= 5'h0;
      end
      // load once, a cycle after entry, when the address is complete;
      // reloading on an empty count would resend the word
      if (state_q == spirk_pkg::SPIRK_READ && rd_start_q
          && !cs_rise && bit_cnt_q == `SPIRK_ADDR_END) begin
        rd_shift_q <= rd_word;
        rd_left_q  <= 5'h10;
      end else if (state_q == spirk_pkg::SPIRK_READ && sck_fall
                   && rd_left_q != 5'h0 && !cs_rise) begin
        // bit 15 first; low bit pulls the line, high bit releases it
        SERIAL_DATA_OUT_OE <= ~rd_shift_q[15];
        rd_shift_q         <= {rd_shift_q[14:0], 1'b0};
        rd_left_q          <= rd_left_q - 5'h1;
      end else if (sck_fall && rd_left_q == 5'h0) begin
        SERIAL_DATA_OUT_OE <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_write_frame;
    wr_commit && wr_addr == `SPIRK_ADDR_SCRATCH;
  endsequence
  sequence s_read_load;
    state_q == spirk_pkg::SPIRK_READ && rd_start_q && !cs_rise;
  endsequence
  sequence s_read_step;
    state_q == spirk_pkg::SPIRK_READ && sck_fall && rd_left_q != 5'h0
    && !cs_rise;
  endsequence
  a_scratch_write: assert property (
    @(posedge REF_CLK) disable iff (RST)
    s_write_frame |=> scratch_q == $past(wr_data))
    else $error("scratch write lost");
  a_key_locks: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (wr_commit && wr_addr == `SPIRK_ADDR_KEY && wr_data == 16'h0)
    |=> !unlocked ##1 !PROTECT_UNLOCKED)
    else $error("key did not lock");
  a_key_unlocks: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (wr_commit && wr_addr == `SPIRK_ADDR_KEY
     && wr_data == `SPIRK_UNLOCK_CODE) |=> unlocked ##1 PROTECT_UNLOCKED)
    else $error("key did not unlock");
  a_locked_discard: assert property (
    @(posedge REF_CLK) disable iff (RST)
    !unlocked |=> !PROT_WR_STROBE)
    else $error("protected write while locked");
  a_od_never_high: assert property (
    @(posedge REF_CLK) disable iff (RST)
    SERIAL_DATA_OUT_O == 1'b0)
    else $error("data out driven high");
  a_od_idle_off: assert property (
    @(posedge REF_CLK) disable iff (RST)
    state_q == spirk_pkg::SPIRK_IDLE ##1 state_q == spirk_pkg::SPIRK_IDLE
    |-> !SERIAL_DATA_OUT_OE)
    else $error("data out driven outside read");
  a_read_release: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (state_q == spirk_pkg::SPIRK_READ && cs_rise) |=> !SERIAL_DATA_OUT_OE)
    else $error("data out held after frame");
  a_read_load: assert property (
    @(posedge REF_CLK) disable iff (RST)
    s_read_load |=> rd_left_q == 5'h10 && rd_shift_q == $past(rd_word))
    else $error("read word not loaded");
  a_read_bit: assert property (
    @(posedge REF_CLK) disable iff (RST)
    s_read_step |=> SERIAL_DATA_OUT_OE != $past(rd_msb))
    else $error("read bit wrong");
  a_soft_reset: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (soft_rst_now && !on_rise && sreset_cnt_q < 3'h6)
    |=> SOFT_RESET_PULSE ##1 !SOFT_RESET_PULSE)
    else $error("soft reset not issued");
  a_reset_limit: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (soft_rst_now && !on_rise && sreset_cnt_q == 3'h6)
    |=> HOLD_OFF && !SOFT_RESET_PULSE)
    else $error("soft reset limit not kept");
  a_on_frees: assert property (
    @(posedge REF_CLK) disable iff (RST)
    on_rise |=> !HOLD_OFF)
    else $error("hold not released");
  a_id_fixed: assert property (
    @(posedge REF_CLK) disable iff (RST)
    cur_addr == `SPIRK_ADDR_RESET_ID |-> rd_word == DEVICE_IDENTIFIER)
    else $error("identifier wrong");
  a_idle_no_mode: assert property (
    @(posedge REF_CLK) disable iff (RST)
    !spi_mode ##1 !spi_mode |-> state_q == spirk_pkg::SPIRK_IDLE)
    else $error("frame active outside four-wire mode");
endmodule // spirk_top

// [tb/spirk_host.sv]
// Purpose: serial bus master model driving the register port
// Assumes: 320 ns serial clock that stands low between frames
// Notes:   data in carries junk while the device answers a read
`timescale 1ns/10ps
module spirk_host (
  // serial pins
  output logic     cs_n,
  output logic     sclk,
  output logic     sdi,
  input  wire logic sdo
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic rw, input logic [14:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    logic [31:0] w;
    w = {rw, a, d};
    q = 16'h0000;
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      // toggling junk in the data phase of a read
      sdi = (rw && i < 16) ? i[0] : w[i];
      #160 sclk = 1'b1;
      if (i < 16) q[i] = sdo;
      #160 sclk = 1'b0;
    end
    #160 cs_n = 1'b1;
    sdi = ~sdi; // released line must not look like the last bit
    #400;
  endtask
endmodule // spirk_host

// [tb/spirk_top_test.sv]
// Purpose: self-checking bench of the serial register port
// Assumes: protected registers modelled by bench signals only
// Notes:   ids are bench parameters, values arbitrary
`timescale 1ns/10ps
module spirk_top_test;
  localparam logic [15:0] DEV_ID  = 16'hc3a5; // arbitrary value
  localparam logic [15:0] MAIN_ID = 16'h0f1e; // arbitrary value
  logic        ref_clk = 0, rst = 1, mode = 1, scope = 0, on_ev = 0;
  logic        hit = 0, sdo_o, sdo_oe, pulse, hold, unl, stb;
  logic [14:0] pa;
  logic [15:0] pd, q, ext = 16'h3c3c;
  wire         cs_n, sclk, sdi, sdo_line;
  int          bad_count = 0, samples_checked = 0, pulses = 0;
  int          strobes = 0;
  always #20 ref_clk = ~ref_clk;
  // pull-up on the open-drain line
  assign sdo_line = sdo_oe ? sdo_o : 1'b1;
  spirk_top #(.DEVICE_IDENTIFIER(DEV_ID), .MAIN_DIE_IDENTITY(MAIN_ID),
    .MAIN_DIE_REVISION(8'h4b), .SECONDARY_DIE_REVISION(8'h2d)) i_spirk_top (
    .REF_CLK(ref_clk), .RST(rst), .INTERFACE_SELECT_PIN(mode),
    .CHIP_SELECT_N(cs_n), .SERIAL_CLOCK_IN(sclk), .SERIAL_DATA_IN(sdi),
    .SERIAL_DATA_OUT_O(sdo_o), .SERIAL_DATA_OUT_OE(sdo_oe),
    .SOFT_RESET_SCOPE_CONFIG(scope), .ON_EVENT(on_ev),
    .SOFT_RESET_PULSE(pulse), .HOLD_OFF(hold), .PROTECT_UNLOCKED(unl),
    .PROT_WR_STROBE(stb), .PROT_WR_ADDR(pa), .PROT_WR_DATA(pd),
    .PROT_ADDR_HIT(hit), .EXT_RD_DATA(ext));
  spirk_host i_spirk_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo_line));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // look between edges, where registered outputs have settled
  always @(negedge ref_clk) begin
    if (pulse === 1'b1) pulses++;
    if (stb === 1'b1) strobes++;
    if (sdo_oe === 1'b1) chk("data out level", 16'h0, {15'h0, sdo_o});
  end
  task automatic sync;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [14:0] a, logic [15:0] d);
    i_spirk_host.xfer(1'b0, a, d, q);
    chk("line during write", 16'hffff, q);
  endtask
  task automatic rd(logic [14:0] a, logic [15:0] e, string n);
    i_spirk_host.xfer(1'b1, a, 16'h0, q);
    chk(n, e, q);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_ids;
    rd(15'h0000, DEV_ID, "device id");
    rd(15'h0001, 16'h4b2d, "revision");
    rd(15'h4000, MAIN_ID, "main die id");
    rd(15'h4008, 16'h0000, "key reset");
    rd(15'h4009, 16'h0000, "scratch reset");
  endtask
  task automatic t_readonly;
    wr(15'h0001, 16'hffff);
    wr(15'h4000, 16'h0000);
    rd(15'h0001, 16'h4b2d, "revision kept");
    rd(15'h4000, MAIN_ID, "main id kept");
  endtask
  task automatic t_mode;
    wr(15'h4009, 16'ha55a);
    rd(15'h4009, 16'ha55a, "scratch");
    sync;
    mode = 1'b0;
    wr(15'h4009, 16'h1234);
    rd(15'h4009, 16'hffff, "silent when deselected");
    sync;
    mode = 1'b1;
    rd(15'h4009, 16'ha55a, "scratch untouched");
  endtask
  task automatic t_lock;
    sync;
    hit = 1'b1;
    wr(15'h4006, 16'h1111);
    chk("locked strobes", 16'h0, 16'(strobes));
    sync;
    hit = 1'b0;
    wr(15'h4008, 16'h9716);
    chk("unlocked", 16'h1, {15'h0, unl});
    rd(15'h4008, 16'h9716, "key value");
    sync;
    hit = 1'b1;
    wr(15'h4006, 16'h2222);
    chk("strobes", 16'h1, 16'(strobes));
    chk("strobe addr", 16'h4006, {1'b0, pa});
    chk("strobe data", 16'h2222, pd);
    rd(15'h4006, ext, "outside data");
    sync;
    hit = 1'b0;
    wr(15'h4008, 16'h0000);
    chk("relocked", 16'h0, {15'h0, unl});
    sync;
    hit = 1'b1;
    wr(15'h4006, 16'h3333);
    chk("relocked strobes", 16'h1, 16'(strobes));
    sync;
    hit = 1'b0;
  endtask
  task automatic t_soft;
    sync;
    scope = 1'b1;
    wr(15'h4009, 16'h5555);
    wr(15'h4008, 16'h9716);
    wr(15'h0000, 16'hffff);
    chk("soft reset pulses", 16'h1, 16'(pulses));
    rd(15'h4009, 16'h0000, "scratch cleared");
    rd(15'h4008, 16'h0000, "key cleared");
    rd(15'h0000, DEV_ID, "id after write");
    sync;
    scope = 1'b0;
    wr(15'h4009, 16'h7777);
    wr(15'h0000, 16'h0000);
    rd(15'h4009, 16'h7777, "scratch kept");
    for (int i = 0; i < 4; i++) wr(15'h0000, 16'h0001);
    chk("six pulses", 16'h6, 16'(pulses));
    chk("not held", 16'h0, {15'h0, hold});
    wr(15'h0000, 16'h0002);
    chk("seventh refused", 16'h6, 16'(pulses));
    chk("held off", 16'h1, {15'h0, hold});
    sync;
    on_ev = 1'b1;
    repeat (4) sync;
    on_ev = 1'b0;
    repeat (4) sync;
    chk("on event frees", 16'h0, {15'h0, hold});
    wr(15'h0000, 16'h0003);
    chk("count restarted", 16'h7, 16'(pulses));
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (4) sync;
    t_ids;
    t_readonly;
    t_mode;
    t_lock;
    t_soft;
    report_and_stop;
  end
  // about 36 frames of 10.8 us each; generous margin
  initial begin
    #3000000;
    bad_count++;
    report_and_stop;
  end
endmodule // spirk_top_test
